// file: design/fsar_resolver.sv
`timescale 1ns/10ps
`include "fsar_map.svh"
// Notes on behaviour
// - every port holds one of four states
// - port state comes from port config field
// - span frames pass except on disabled ports
// - reserved classes span: tag, table, control, reg
// - arp span: valid tag bit else arp reg
// - group classes span: tag else group reg
// - other span: tag else table, else none
// - management frames get reserved buffer space
// - management frames skip rate, storm, discard
// - reserved classes mgmt: tag, table, control, reg
// - arp mgmt: valid tag bit else arp reg
// - group classes mgmt: tag else group reg
// - other mgmt: tag else table, else none
// - cross-vlan frames bypass boundary and violation
// - reserved classes xvlan: tag, table, control, reg
// - arp xvlan: valid tag bit else arp reg
// - group classes xvlan: tag else group reg
// - other xvlan: tag else table, else none
// - ipv4 group class from da, type, version, protocol
module fsar_resolver
  import fsar_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frm_valid,
  input  wire logic [3:0]  frm_class,
  input  wire logic [2:0]  frm_src_port,
  input  wire logic [47:0] frm_da,
  input  wire logic [15:0] frm_ethertype,
  input  wire logic [3:0]  frm_ip_version,
  input  wire logic [7:0]  frm_ip_proto,
  input  wire logic        tag_span,
  input  wire logic        tag_span_valid,
  input  wire logic        tag_mgmt,
  input  wire logic        tag_mgmt_valid,
  input  wire logic        tag_vlan_bypass,
  input  wire logic        tag_vlan_bypass_override_valid,
  input  wire logic        lt_hit,
  input  wire logic        lt_span,
  input  wire logic        lt_mgmt,
  input  wire logic        lt_vlan_bypass,
  input  wire logic        ct_hit,
  input  wire logic        ct_span,
  input  wire logic        ct_mgmt,
  input  wire logic        ct_vlan_bypass,
  output logic             res_valid,
  output logic             res_span,
  output logic             res_mgmt,
  output logic             res_vlan_bypass,
  output logic             res_stp_drop,
  output logic             res_learn_allow,
  output logic             res_buf_reserve,
  output logic             res_rate_exempt,
  output logic             res_storm_exempt,
  output logic             res_discard_exempt,
  output logic             res_vlan_boundary_pass,
  output logic             res_violation_bypass,
  output logic [11:0]      spanning_port_state_field
);

  logic [15:0] igmp_mld_attribute_config_ff;
  logic [15:0] arp_attribute_config_ff;
  logic [15:0] reserved_address_attribute_config_ff;
  logic [15:0] port_spanning_state_config_ff [`FSAR_NUM_PORTS];

  logic        acc;
  logic        setup;
  logic        wr_en;
  logic [5:0]  idx;
  logic [2:0]  port_sel;
  logic        addr_hit;
  logic [15:0] rd_word;
  logic [31:0] prdata_ff;
  logic        err_ff;

  fsar_class_t  cls;
  fsar_grp_t    grp;
  fsar_pstate_t cur_state;
  logic         grp_match;
  logic [2:0]   tag_bit;
  logic [2:0]   tag_vld;
  logic [2:0]   lt_bit;
  logic [2:0]   ct_bit;
  logic [2:0]   nxt_attr;
  logic         nxt_drop;
  logic         nxt_learn;

  logic         res_valid_ff;
  logic [2:0]   attr_ff;
  logic         drop_ff;
  logic         learn_ff;
  fsar_pstate_t state_ff;
  fsar_class_t  class_ff;

  // apb slave: zero wait states, data prepared in the setup cycle
  assign setup = psel & ~penable;
  assign acc   = psel & penable;
  assign idx   = paddr[`FSAR_IDX_MSB:`FSAR_IDX_LSB];
  assign port_sel = 3'(idx - `FSAR_IDX_PORT0);
  assign wr_en = acc & pwrite & addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    rd_word  = 16'h0000;
    if (paddr[1:0] != `FSAR_BYTE_OFS) begin
      addr_hit = 1'b0;
    end else begin
      case (idx)
        `FSAR_IDX_IGMP_MLD: rd_word = igmp_mld_attribute_config_ff;
        `FSAR_IDX_ARP:      rd_word = arp_attribute_config_ff;
        `FSAR_IDX_RESERVED: rd_word = reserved_address_attribute_config_ff;
        `FSAR_IDX_STATUS: begin
          rd_word = {5'h00, state_ff, drop_ff, attr_ff, res_valid_ff,
                     class_ff};
        end
        default: begin
          if (idx >= `FSAR_IDX_PORT0 && idx <= `FSAR_IDX_PORT5) begin
            rd_word = port_spanning_state_config_ff[port_sel];
          end else begin
            addr_hit = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      err_ff    <= 1'b0;
    end else if (setup) begin
      prdata_ff <= {16'h0000, rd_word};
      err_ff    <= ~addr_hit;
    end
  end

  assign pready  = acc;
  assign pslverr = acc & err_ff;
  assign prdata  = prdata_ff;

  // status word is read only; writes to it are dropped silently
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      igmp_mld_attribute_config_ff         <= `FSAR_ATTR_CFG_RST;
      arp_attribute_config_ff              <= `FSAR_ATTR_CFG_RST;
      reserved_address_attribute_config_ff <= `FSAR_ATTR_CFG_RST;
    end else if (wr_en) begin
      case (idx)
        `FSAR_IDX_IGMP_MLD: begin
          igmp_mld_attribute_config_ff <= pwdata[15:0];
        end
        `FSAR_IDX_ARP: begin
          arp_attribute_config_ff <= pwdata[15:0];
        end
        `FSAR_IDX_RESERVED: begin
          reserved_address_attribute_config_ff <= pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  generate
    for (genvar p = 0; p < `FSAR_NUM_PORTS; p++) begin : g_port
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          port_spanning_state_config_ff[p] <= `FSAR_PORT_CFG_RST;
        end else if (wr_en && idx == 6'(`FSAR_IDX_PORT0 + p)) begin
          port_spanning_state_config_ff[p] <= pwdata[15:0];
        end
      end
      assign spanning_port_state_field[2*p+1:2*p] =
        port_spanning_state_config_ff[p]
          [`FSAR_PSTATE_MSB:`FSAR_PSTATE_LSB];
    end
  endgenerate

  // group matcher overrides the external class for this one case
  assign grp_match = frm_da[47:24] == `FSAR_V4_MCAST_OUI
                   && frm_ethertype == `FSAR_ETYPE_IPV4
                   && frm_ip_version == `FSAR_IP_VER4
                   && frm_ip_proto == `FSAR_PROTO_GRP;
  assign cls = grp_match ? ipv4_group_mgmt_class
                         : fsar_class_t'(frm_class);

  always_comb begin
    case (cls)
      cls_bpdu, cls_slow, port_auth_class, reserved_range_a_class,
      reserved_range_b_class, attribute_registration_class,
      reserved_range_c_class, reserved_range_d_class: grp = grp_rsv;
      cls_arp, cls_rarp:                               grp = grp_arp;
      ipv4_group_mgmt_class, listener_discovery_v4type_class,
      listener_discovery_v6type_class:                 grp = grp_igmp;
      default:                                         grp = grp_other;
    endcase
  end

  assign tag_bit = {tag_vlan_bypass, tag_mgmt, tag_span};
  assign tag_vld = {tag_vlan_bypass_override_valid, tag_mgmt_valid,
                    tag_span_valid};
  assign lt_bit  = {lt_vlan_bypass, lt_mgmt, lt_span};
  assign ct_bit  = {ct_vlan_bypass, ct_mgmt, ct_span};

  // one priority chain per attribute: span, management, cross-vlan
  generate
    for (genvar a = 0; a < `FSAR_NUM_ATTR; a++) begin : g_attr
      always_comb begin
        case (grp)
          grp_rsv: begin
            if (tag_vld[a])
              nxt_attr[a] = tag_bit[a];
            else if (lt_hit)
              nxt_attr[a] = lt_bit[a];
            else if (ct_hit)
              nxt_attr[a] = ct_bit[a];
            else
              nxt_attr[a] = reserved_address_attribute_config_ff
                              [`FSAR_ATTR_LSB + a];
          end
          grp_arp: begin
            nxt_attr[a] = tag_vld[a] ? tag_bit[a]
                        : arp_attribute_config_ff
                            [`FSAR_ATTR_LSB + a];
          end
          grp_igmp: begin
            nxt_attr[a] = tag_vld[a] ? tag_bit[a]
                        : igmp_mld_attribute_config_ff
                            [`FSAR_ATTR_LSB + a];
          end
          default: begin
            // no control table or register fallback for other frames
            nxt_attr[a] = tag_vld[a] ? tag_bit[a]
                        : (lt_hit & lt_bit[a]);
          end
        endcase
      end
    end
  endgenerate

  // out of range source port is treated as disabled, the safe side
  always_comb begin
    if (frm_src_port <= `FSAR_LAST_PORT) begin
      cur_state = fsar_pstate_t'(port_spanning_state_config_ff
        [frm_src_port][`FSAR_PSTATE_MSB:`FSAR_PSTATE_LSB]);
    end else begin
      cur_state = pst_disabled;
    end
  end

  always_comb begin
    nxt_learn = 1'b0;
    case (cur_state)
      pst_disabled: nxt_drop = 1'b1;
      pst_forwarding: begin
        nxt_drop  = 1'b0;
        nxt_learn = 1'b1;
      end
      pst_learning: begin
        nxt_drop  = ~nxt_attr[`FSAR_SPAN_BIT];
        nxt_learn = 1'b1;
      end
      default: nxt_drop = ~nxt_attr[`FSAR_SPAN_BIT];
    endcase
  end

  // results held until the next frame; valid marks the new set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_valid_ff <= 1'b0;
    end else begin
      res_valid_ff <= frm_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      attr_ff  <= 3'b000;
      drop_ff  <= 1'b0;
      learn_ff <= 1'b0;
      state_ff <= pst_disabled;
      class_ff <= cls_other;
    end else if (frm_valid) begin
      attr_ff  <= nxt_attr;
      drop_ff  <= nxt_drop;
      learn_ff <= nxt_learn;
      state_ff <= cur_state;
      class_ff <= cls;
    end
  end

  assign res_valid       = res_valid_ff;
  assign res_span        = attr_ff[`FSAR_SPAN_BIT];
  assign res_mgmt        = attr_ff[`FSAR_MGMT_BIT];
  assign res_vlan_bypass = attr_ff[`FSAR_XVLAN_BIT];
  assign res_stp_drop    = drop_ff;
  assign res_learn_allow = learn_ff;
  assign res_buf_reserve    = attr_ff[`FSAR_MGMT_BIT];
  assign res_rate_exempt    = attr_ff[`FSAR_MGMT_BIT];
  assign res_storm_exempt   = attr_ff[`FSAR_MGMT_BIT];
  assign res_discard_exempt = attr_ff[`FSAR_MGMT_BIT];
  assign res_vlan_boundary_pass = attr_ff[`FSAR_XVLAN_BIT];
  assign res_violation_bypass   = attr_ff[`FSAR_XVLAN_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_rsv_no_source;
    frm_valid && grp == grp_rsv && !tag_vlan_bypass_override_valid
      && !lt_hit && !ct_hit;
  endsequence

  sequence s_other_no_source;
    frm_valid && grp == grp_other && !tag_mgmt_valid && !lt_hit;
  endsequence

  sequence s_on_disabled;
    frm_valid && cur_state == pst_disabled;
  endsequence

  a_tag_span_first:
    assert property (frm_valid && tag_span_valid |=>
      res_valid && res_span == $past(tag_span))
    else $error("valid tag span bit did not win");

  a_arp_reg_span:
    assert property (frm_valid && grp == grp_arp && !tag_span_valid |=>
      res_span == $past(arp_attribute_config_ff[`FSAR_SPAN_BIT]))
    else $error("arp span not taken from arp config");

  a_group_reg_mgmt:
    assert property (frm_valid && grp == grp_igmp && !tag_mgmt_valid |=>
      res_mgmt == $past(igmp_mld_attribute_config_ff[`FSAR_MGMT_BIT]))
    else $error("group mgmt not taken from group config");

  a_rsv_reg_xvlan:
    assert property (s_rsv_no_source |=> res_vlan_bypass ==
      $past(reserved_address_attribute_config_ff[`FSAR_XVLAN_BIT]))
    else $error("reserved xvlan fallback wrong");

  a_rsv_ct_mgmt:
    assert property (frm_valid && grp == grp_rsv && !tag_mgmt_valid
      && !lt_hit && ct_hit |=> res_mgmt == $past(ct_mgmt))
    else $error("control table mgmt bit not used");

  a_other_mgmt_none:
    assert property (s_other_no_source ##1 res_valid |-> !res_mgmt)
    else $error("other frame marked management without source");

  a_disabled_drop:
    assert property (s_on_disabled |=> res_stp_drop)
    else $error("frame on disabled port not dropped");

  a_span_survives:
    assert property (res_valid && res_span && state_ff != pst_disabled
      |-> !res_stp_drop)
    else $error("span frame dropped by port state");

  a_mgmt_shield:
    assert property (frm_valid && tag_mgmt_valid && tag_mgmt |=>
      res_buf_reserve && res_rate_exempt && res_storm_exempt
      && res_discard_exempt)
    else $error("management frame not shielded");

  a_group_match:
    assert property (frm_valid && grp_match && !tag_vlan_bypass_override_valid
      |=> res_vlan_bypass ==
        $past(igmp_mld_attribute_config_ff[`FSAR_XVLAN_BIT]))
    else $error("ipv4 group frame not classed");

  a_port_write:
    assert property (acc && pwrite && paddr == {`FSAR_IDX_PORT0, 2'b00}
      |=> spanning_port_state_field[1:0] == $past(pwdata[1:0]))
    else $error("port state write not applied");

  a_result_once:
    assert property (frm_valid |=> res_valid
      ##1 (res_valid == $past(frm_valid)))
    else $error("result valid not one per frame");

endmodule

// file: design/fsar_map.svh
`ifndef FSAR_MAP_SVH
`define FSAR_MAP_SVH

// register indices; byte address is four times the index
`define FSAR_IDX_IGMP_MLD   6'h0c
`define FSAR_IDX_ARP        6'h0d
`define FSAR_IDX_PORT0      6'h13
`define FSAR_IDX_PORT5      6'h18
`define FSAR_IDX_RESERVED   6'h3e
`define FSAR_IDX_STATUS     6'h30

`define FSAR_IDX_MSB        7
`define FSAR_IDX_LSB        2
`define FSAR_BYTE_OFS       2'b00

// attribute bits in the three attribute config registers
`define FSAR_SPAN_BIT       0
`define FSAR_MGMT_BIT       1
`define FSAR_XVLAN_BIT      2
`define FSAR_ATTR_LSB       0
`define FSAR_NUM_ATTR       3

// spanning state field in each port config register
`define FSAR_PSTATE_MSB     1
`define FSAR_PSTATE_LSB     0
`define FSAR_NUM_PORTS      6
`define FSAR_LAST_PORT      3'h5

`define FSAR_ATTR_CFG_RST   16'h0000
`define FSAR_PORT_CFG_RST   16'h0003
`define FSAR_REG_W          16
`define FSAR_BUS_W          32

// ipv4 group management matcher
`define FSAR_V4_MCAST_OUI   24'h01005e
`define FSAR_ETYPE_IPV4     16'h0800
`define FSAR_IP_VER4        4'h4
`define FSAR_PROTO_GRP      8'h02

`endif

// file: design/fsar_pkg.sv
package fsar_pkg;

  typedef enum logic [3:0] {
    cls_other                       = 4'h0,
    cls_bpdu                        = 4'h1,
    cls_slow                        = 4'h2,
    port_auth_class                 = 4'h3,
    reserved_range_a_class          = 4'h4,
    reserved_range_b_class          = 4'h5,
    attribute_registration_class    = 4'h6,
    reserved_range_c_class          = 4'h7,
    reserved_range_d_class          = 4'h8,
    cls_arp                         = 4'h9,
    cls_rarp                        = 4'ha,
    ipv4_group_mgmt_class           = 4'hb,
    listener_discovery_v4type_class = 4'hc,
    listener_discovery_v6type_class = 4'hd
  } fsar_class_t;

  typedef enum logic [1:0] {
    grp_other = 2'b00,
    grp_rsv   = 2'b01,
    grp_arp   = 2'b10,
    grp_igmp  = 2'b11
  } fsar_grp_t;

  typedef enum logic [1:0] {
    pst_disabled   = 2'b00,
    pst_blocking   = 2'b01,
    pst_learning   = 2'b10,
    pst_forwarding = 2'b11
  } fsar_pstate_t;

endpackage

// file: tb/fsar_lookup_model.sv
`timescale 1ns/10ps
module fsar_lookup_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [47:0] frm_da,
  output logic             lt_hit,
  output logic             lt_span,
  output logic             lt_mgmt,
  output logic             lt_vlan_bypass,
  output logic             ct_hit,
  output logic             ct_span,
  output logic             ct_mgmt,
  output logic             ct_vlan_bypass
);
  logic [7:0] tbl_ff [16];
  // fixed contents, no learning; answers in the same cycle as the lookup
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        tbl_ff[i] <= 8'(i * 8'h3b) ^ 8'ha5;
      end
    end
  end
  assign {ct_vlan_bypass, ct_mgmt, ct_span, ct_hit} = tbl_ff[frm_da[3:0]][7:4];
  assign {lt_vlan_bypass, lt_mgmt, lt_span, lt_hit} = tbl_ff[frm_da[3:0]][3:0];
endmodule

// file: tb/fsar_resolver_tb.sv
`timescale 1ns/10ps
module fsar_resolver_tb;
  import fsar_pkg::*;
  logic        sys_clk, rst, psel, penable, pwrite, frm_valid, rerr;
  logic        pready, pslverr, res_valid, res_span, res_mgmt;
  logic        res_vlan_bypass, res_stp_drop, res_learn_allow;
  logic        res_buf_reserve, res_rate_exempt, res_storm_exempt;
  logic        res_discard_exempt, res_vlan_boundary_pass;
  logic        res_violation_bypass, lt_hit, lt_span, lt_mgmt;
  logic        lt_vlan_bypass, ct_hit, ct_span, ct_mgmt, ct_vlan_bypass;
  logic [5:0]  tg;
  logic [7:0]  paddr, frm_ip_proto;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  frm_class, frm_ip_version;
  logic [2:0]  frm_src_port;
  logic [47:0] frm_da;
  logic [15:0] frm_ethertype, r0c, r0d, r3e;
  logic [11:0] spanning_port_state_field;
  logic [1:0]  pst [6];
  int          n_errors, n_checks, seed, cyc;

  fsar_resolver u_dut (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frm_valid, .frm_class, .frm_src_port, .frm_da,
    .frm_ethertype, .frm_ip_version, .frm_ip_proto,
    .tag_span_valid(tg[5]), .tag_span(tg[4]), .tag_mgmt_valid(tg[3]),
    .tag_mgmt(tg[2]), .tag_vlan_bypass_override_valid(tg[1]),
    .tag_vlan_bypass(tg[0]), .lt_hit, .lt_span, .lt_mgmt, .lt_vlan_bypass,
    .ct_hit, .ct_span, .ct_mgmt, .ct_vlan_bypass, .res_valid, .res_span,
    .res_mgmt, .res_vlan_bypass, .res_stp_drop, .res_learn_allow,
    .res_buf_reserve, .res_rate_exempt, .res_storm_exempt,
    .res_discard_exempt, .res_vlan_boundary_pass, .res_violation_bypass,
    .spanning_port_state_field
  );

  fsar_lookup_model u_lookup (
    .sys_clk, .rst, .frm_da, .lt_hit, .lt_span, .lt_mgmt, .lt_vlan_bypass,
    .ct_hit, .ct_span, .ct_mgmt, .ct_vlan_bypass
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // cut a hang short; the whole run needs about 1400 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s saw %h want %h", $time, what, seen,
               exp);
    end
  endtask

  function automatic logic pick(input logic [3:0] c,
                                input logic tv, tb, lh, lb, ch, cb, r3, rd,
                                rc);
    case (c)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
        return tv ? tb : lh ? lb : ch ? cb : r3;
      4'h9, 4'ha:
        return tv ? tb : rd;
      4'hb, 4'hc, 4'hd:
        return tv ? tb : rc;
      default:
        return tv ? tb : lh & lb;
    endcase
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k, 1, "ready");
    if (w) begin
      case (a)
        8'h30: r0c = d[15:0];
        8'h34: r0d = d[15:0];
        8'hf8: r3e = d[15:0];
        8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60:
          pst[(a - 8'h4c) >> 2] = d[1:0];
        default: ;
      endcase
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic er);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, "read data");
    chk(rerr, er, "slave error");
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(rerr, 0, "write error");
    rchk(a, {16'h0, d[15:0]}, 1'b0);
  endtask

  task automatic send(input logic [3:0] c, input logic [47:0] da,
                      input logic [15:0] et, input logic [3:0] ver,
                      input logic [7:0] pr, input logic [5:0] t,
                      input logic [2:0] p);
    logic [3:0] ec;
    logic [1:0] st;
    logic       es, em, ex;
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm_class <= c;
    frm_da <= da;
    frm_ethertype <= et;
    frm_ip_version <= ver;
    frm_ip_proto <= pr;
    tg <= t;
    frm_src_port <= p;
    #1;
    chk(res_valid, 0, "valid low");
    ec = (da[47:24] == 24'h01005e && et == 16'h0800 && ver == 4'h4 &&
          pr == 8'h02) ? 4'hb : c;
    es = pick(ec, t[5], t[4], lt_hit, lt_span, ct_hit, ct_span, r3e[0],
              r0d[0], r0c[0]);
    em = pick(ec, t[3], t[2], lt_hit, lt_mgmt, ct_hit, ct_mgmt, r3e[1],
              r0d[1], r0c[1]);
    ex = pick(ec, t[1], t[0], lt_hit, lt_vlan_bypass, ct_hit,
              ct_vlan_bypass, r3e[2], r0d[2], r0c[2]);
    st = (p > 3'h5) ? 2'b00 : pst[p];
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    #1;
    chk(res_valid, 1, "valid");
    chk(res_span, es, "span");
    chk(res_mgmt, em, "mgmt");
    chk(res_vlan_bypass, ex, "xvlan");
    chk({res_buf_reserve, res_rate_exempt, res_storm_exempt,
         res_discard_exempt}, {4{em}}, "mgmt copies");
    chk({res_vlan_boundary_pass, res_violation_bypass}, {2{ex}},
        "xvlan copies");
    chk(res_stp_drop, st == 2'b00 || (st != 2'b11 && !es), "drop");
    chk(res_learn_allow, st[1], "learn");
    chk(spanning_port_state_field, {pst[5], pst[4], pst[3], pst[2],
        pst[1], pst[0]}, "port states");
  endtask

  initial begin
    {psel, penable, pwrite, frm_valid, tg, paddr, pwdata} = '0;
    {frm_class, frm_src_port, frm_da, frm_ethertype} = '0;
    {frm_ip_version, frm_ip_proto, n_errors, n_checks, cyc} = '0;
    {r0c, r0d, r3e} = '0;
    for (int i = 0; i < 6; i++) begin
      pst[i] = 2'b11;
    end
    seed = 69;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(8'h30, 32'h0, 1'b0);
    rchk(8'h34, 32'h0, 1'b0);
    rchk(8'hf8, 32'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rchk(8'h4c + 8'(4 * i), 32'h3, 1'b0);
    end
    rchk(8'h08, 32'h0, 1'b1);
    rchk(8'h32, 32'h0, 1'b1);
    apb(1'b1, 8'h08, 32'hffff);
    chk(rerr, 1, "unmapped write");
    apb(1'b1, 8'hc0, 32'hffff);
    chk(rerr, 0, "status write");
    rchk(8'hc0, 32'h0, 1'b0);
    rchk(8'h30, 32'h0, 1'b0);
    // ipv4 group matcher hit and near miss on a plain frame
    wrc(8'h30, 32'h7);
    send(4'h0, 48'h01005e000001, 16'h0800, 4'h4, 8'h02, 6'h0, 3'h0);
    rchk(8'hc0, 32'h6eb, 1'b0);
    send(4'h0, 48'h01005e000001, 16'h0800, 4'h4, 8'h03, 6'h0, 3'h0);
    rchk(8'hc0, 32'h600, 1'b0);
    for (int n = 0; n < 400; n++) begin
      if (n % 40 == 0) begin
        wrc(8'h30, $random(seed));
        wrc(8'h34, $random(seed));
        wrc(8'hf8, $random(seed));
        for (int i = 0; i < 6; i++) begin
          wrc(8'h4c + 8'(4 * i), $random(seed));
        end
      end
      send($random(seed),
           ($random(seed) & 1) ? {24'h01005e, 24'($random(seed))}
                               : {$random(seed), 16'($random(seed))},
           ($random(seed) & 1) ? 16'h0800 : 16'($random(seed)),
           ($random(seed) & 1) ? 4'h4 : 4'($random(seed)),
           ($random(seed) & 1) ? 8'h02 : 8'($random(seed)),
           $random(seed), $random(seed));
    end
    wrap_up();
  end
endmodule
